//--- rtl/tsb_pkg.sv
/*
 * Shared constants, types and helpers of the thermometer SMBus slave
 * and its standby/conversion control.
 * Assumes a 10 MHz system clock and a separate link sampling clock.
 */
// Contract
// - Sleep pin low or the halt bit set stops the converter, entering standby.
// - Standby keeps all registers and leaves the serial slave fully working.
// - In pin standby a single conversion command is acknowledged but ignored.
// - With only the halt bit set, a single conversion command still converts.
// - Sleep pin low overrides every software conversion request.
// - Standby during a conversion aborts it; old results stay readable.
// - One conversion of both channels takes 125 ms before results latch.
// - Both channels answer to the same single slave address.
// - Only Write Byte, Read Byte, Send Byte and Receive Byte are supported.
// - Receive Byte returns the register chosen by the last command byte other than 0Fh.
// - Results are 8-bit two's complement, 1 degree per bit, MSB first.
// - Half a degree is added before quantizing, so results round.
// - Write Byte: address, command, data, each acknowledged; data stored.
// - Read phase of Read Byte returns the register its command selected.
// - Command 0Fh as Send Byte requests a single conversion.
// - Sleep pin low means standby, high means normal operation.
package tsb_pkg;

    localparam int CLK_HZ = 10_000_000;
    localparam int CONV_TIME_MS = 125;
    localparam int CONV_CYCLES = CLK_HZ / 1000 * CONV_TIME_MS;
    localparam int CONV_CNT_W = 21;

    localparam int RAW_W = 11;
    localparam int REG_IDX_W = 4;
    localparam int REG_DEPTH = 16;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    localparam logic [7:0] CMD_LOCAL_TEMP = 8'h00;
    localparam logic [7:0] CMD_REMOTE_TEMP = 8'h01;
    localparam logic [7:0] CMD_STATUS = 8'h02;
    localparam logic [7:0] CMD_RD_CFG = 8'h03;
    localparam logic [7:0] CMD_RD_RATE = 8'h04;
    localparam logic [7:0] CMD_RD_LAST = 8'h08;
    localparam logic [7:0] CMD_WR_CFG = 8'h09;
    localparam logic [7:0] CMD_WR_LAST = 8'h0E;
    localparam logic [7:0] CMD_SINGLE_CONV = 8'h0F;
    localparam logic [7:0] WR_TO_RD_OFFSET = 8'h06;

    localparam int CFG_HALT_BIT = 6;
    localparam int STATUS_BUSY_BIT = 7;

    localparam logic [7:0] RST_TEMP = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h02;
    localparam logic [7:0] RST_THIGH = 8'h7F;
    localparam logic [7:0] RST_TLOW = 8'hC9;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_ADDR     = 4'h1,
        ST_ACK_ADDR = 4'h2,
        ST_CMD      = 4'h3,
        ST_ACK_CMD  = 4'h4,
        ST_DATA     = 4'h5,
        ST_ACK_DATA = 4'h6,
        ST_TX       = 4'h7,
        ST_TX_ACK   = 4'h8
    } tsb_smb_state_e;

    // Value after reset of each byte register, by read command index
    function automatic logic [7:0] por_value(input int idx);
        case (idx)
            4: por_value = RST_RATE;
            5, 7: por_value = RST_THIGH;
            6, 8: por_value = RST_TLOW;
            default: por_value = RST_CFG;
        endcase
    endfunction

    // Quarter-degree raw value to rounded whole degrees, saturated
    function automatic logic [7:0] round_temp(input logic signed [10:0] raw);
        logic signed [11:0] sum;
        logic signed [9:0] deg;
        sum = raw + 12'sh002;
        deg = sum[11:2];
        if (deg > 10'sh07F) begin
            round_temp = 8'h7F;
        end else if (deg < -10'sh080) begin
            round_temp = 8'h80;
        end else begin
            round_temp = deg[7:0];
        end
    endfunction

endpackage

//--- rtl/tsb_mem_if.sv
/*
 * Write and read port bundle between the SMBus slave and its
 * byte register memory. Both ends run on the link clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface tsb_mem_if;
    logic we;
    logic [3:0] waddr;
    logic [7:0] wdata;
    logic [3:0] raddr;
    logic [7:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr,
                  input rdata);
    modport mem (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface
`default_nettype wire

//--- rtl/tsb_regmem.sv
/*
 * Byte registers written by the host: configuration, rate and the four
 * limits. Read data is registered. Assumes a synchronous reset on clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module tsb_regmem (
    input wire logic clk_i,
    input wire logic rst_i,
    tsb_mem_if.mem bus
);
    import tsb_pkg::*;

    logic [7:0] mem_r [REG_DEPTH];

    genvar i;
    generate
        for (i = 0; i < REG_DEPTH; i++) begin : g_word
            // Contents survive standby; only reset and host writes change them
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    mem_r[i] <= por_value(i);
                end else if (bus.we && bus.waddr == REG_IDX_W'(i)) begin
                    mem_r[i] <= bus.wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus.rdata <= 8'h00;
        end else begin
            bus.rdata <= mem_r[bus.raddr];
        end
    end

endmodule
`default_nettype wire

//--- rtl/tsb_temp_ctrl.sv
/*
 * Thermometer SMBus slave with standby and conversion control.
 * The slave oversamples the bus pins on link_clk_i; the conversion
 * engine runs on clk_i. Raw ADC words arrive on clk_i in quarter degrees.
 */
`timescale 1ns/1ns
`default_nettype none
module tsb_temp_ctrl #(
    parameter int CONV_CYCLES_P = tsb_pkg::CONV_CYCLES,
    parameter logic [6:0] SLAVE_ADDR = 7'h2A
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic hw_sleep_n_i,
    input wire logic signed [tsb_pkg::RAW_W-1:0] adc_local_i,
    input wire logic signed [tsb_pkg::RAW_W-1:0] adc_remote_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic adc_run_o,
    output logic standby_o
);
    import tsb_pkg::*;

    // System clock domain: standby and conversion control
    logic sleep_m_r;
    logic sleep_s_r;
    logic halt_m_r;
    logic halt_s_r;
    logic halt_d_r;
    logic os_m_r;
    logic os_s_r;
    logic os_d_r;
    logic busy_r;
    logic standby_r;
    logic done_tog_r;
    logic [CONV_CNT_W-1:0] conv_cnt_r;
    logic [7:0] res_local_r;
    logic [7:0] res_remote_r;
    logic hw_sb;
    logic os_ev;
    logic halt_rise;
    logic conv_start;
    logic conv_abort;
    logic conv_done;

    // Link domain: SMBus slave
    logic lrst_m_r;
    logic lrst_r;
    logic scl_m_r;
    logic scl_s_r;
    logic scl_d_r;
    logic sda_m_r;
    logic sda_s_r;
    logic sda_d_r;
    logic busy_lm_r;
    logic busy_ls_r;
    logic dt_m_r;
    logic dt_s_r;
    logic dt_d_r;
    logic [7:0] temp_local_r;
    logic [7:0] temp_remote_r;
    tsb_smb_state_e state_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic [7:0] cmd_r;
    logic [7:0] ptr_r;
    logic rd_r;
    logic ack_r;
    logic oe_r;
    logic os_tog_r;
    logic halt_cfg_r;
    logic we_r;
    logic [3:0] waddr_r;
    logic [7:0] wdata_r;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic rx_state;
    logic [7:0] rd_byte;

    // Write commands select the same word as their read twins
    function automatic logic wr_cmd(input logic [7:0] c);
        return (c >= CMD_WR_CFG) && (c <= CMD_WR_LAST);
    endfunction

    tsb_mem_if mbus ();

    tsb_regmem u_regmem (
        .clk_i(link_clk_i),
        .rst_i(lrst_r),
        .bus(mbus.mem)
    );

    assign mbus.we = we_r;
    assign mbus.waddr = waddr_r;
    assign mbus.wdata = wdata_r;
    assign mbus.raddr = wr_cmd(ptr_r) ? 4'(ptr_r - WR_TO_RD_OFFSET)
        : ptr_r[3:0];

    // Pin and cross-domain inputs, two flops each; halt and single requests get a third flop for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_m_r <= 1'b1;
            sleep_s_r <= 1'b1;
            halt_m_r <= 1'b0;
            halt_s_r <= 1'b0;
            halt_d_r <= 1'b0;
            os_m_r <= 1'b0;
            os_s_r <= 1'b0;
            os_d_r <= 1'b0;
        end else begin
            sleep_m_r <= hw_sleep_n_i;
            sleep_s_r <= sleep_m_r;
            halt_m_r <= halt_cfg_r;
            halt_s_r <= halt_m_r;
            halt_d_r <= halt_s_r;
            os_m_r <= os_tog_r;
            os_s_r <= os_m_r;
            os_d_r <= os_s_r;
        end
    end

    assign hw_sb = ~sleep_s_r;
    assign os_ev = os_s_r ^ os_d_r;
    assign halt_rise = halt_s_r & ~halt_d_r;
    // Pin standby blocks both free-running and single requests
    assign conv_start = ~hw_sb & ~busy_r & (~halt_s_r | os_ev);
    assign conv_abort = busy_r & (hw_sb | halt_rise);
    assign conv_done = busy_r & ~conv_abort
        & (conv_cnt_r == CONV_CNT_W'(CONV_CYCLES_P - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b0;
            conv_cnt_r <= '0;
        end else if (conv_abort || conv_done) begin
            busy_r <= 1'b0;
            conv_cnt_r <= '0;
        end else if (conv_start) begin
            busy_r <= 1'b1;
            conv_cnt_r <= '0;
        end else if (busy_r) begin
            conv_cnt_r <= conv_cnt_r + CONV_CNT_W'(1);
        end
    end

    // Results only move on a finished conversion; an abort leaves them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_local_r <= RST_TEMP;
            res_remote_r <= RST_TEMP;
            done_tog_r <= 1'b0;
        end else if (conv_done) begin
            res_local_r <= round_temp(adc_local_i);
            res_remote_r <= round_temp(adc_remote_i);
            done_tog_r <= ~done_tog_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            standby_r <= 1'b0;
        end else begin
            standby_r <= hw_sb | (halt_s_r & ~busy_r);
        end
    end

    assign adc_run_o = busy_r;
    assign standby_o = standby_r;

    // Link domain reset and pin synchronisers
    always_ff @(posedge link_clk_i) begin
        lrst_m_r <= rst_i;
        lrst_r <= lrst_m_r;
    end

    always_ff @(posedge link_clk_i) begin
        if (lrst_r) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
            busy_lm_r <= 1'b0;
            busy_ls_r <= 1'b0;
            dt_m_r <= 1'b0;
            dt_s_r <= 1'b0;
            dt_d_r <= 1'b0;
        end else begin
            scl_m_r <= scl_i;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= sda_i;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
            busy_lm_r <= busy_r;
            busy_ls_r <= busy_lm_r;
            dt_m_r <= done_tog_r;
            dt_s_r <= dt_m_r;
            dt_d_r <= dt_s_r;
        end
    end

    // Result words are stable for a whole conversion after the toggle
    always_ff @(posedge link_clk_i) begin
        if (lrst_r) begin
            temp_local_r <= RST_TEMP;
            temp_remote_r <= RST_TEMP;
        end else if (dt_s_r ^ dt_d_r) begin
            temp_local_r <= res_local_r;
            temp_remote_r <= res_remote_r;
        end
    end

    assign scl_rise = scl_s_r & ~scl_d_r;
    assign scl_fall = ~scl_s_r & scl_d_r;
    assign bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    assign bus_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
    assign rx_state = (state_r == ST_ADDR) || (state_r == ST_CMD)
        || (state_r == ST_DATA);

    // Both channels share one pointer space behind one address
    always_comb begin
        case (ptr_r)
            CMD_LOCAL_TEMP: rd_byte = temp_local_r;
            CMD_REMOTE_TEMP: rd_byte = temp_remote_r;
            CMD_STATUS: begin
                rd_byte = 8'h00;
                rd_byte[STATUS_BUSY_BIT] = busy_ls_r;
            end
            default: begin
                if (ptr_r >= CMD_RD_CFG && ptr_r <= CMD_WR_LAST) begin
                    rd_byte = mbus.rdata;
                end else begin
                    rd_byte = 8'h00;
                end
            end
        endcase
    end

    // Data changes only while SCL is low; ACK held for one bit time
    always_ff @(posedge link_clk_i) begin
        if (lrst_r) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            cmd_r <= 8'h00;
            ptr_r <= 8'h00;
            rd_r <= 1'b0;
            ack_r <= 1'b0;
            oe_r <= 1'b0;
            os_tog_r <= 1'b0;
            halt_cfg_r <= 1'b0;
            we_r <= 1'b0;
            waddr_r <= 4'h0;
            wdata_r <= 8'h00;
        end else begin
            we_r <= 1'b0;
            if (bus_start) begin
                state_r <= ST_ADDR;
                cnt_r <= 4'h0;
                oe_r <= 1'b0;
            end else if (bus_stop) begin
                state_r <= ST_IDLE;
                oe_r <= 1'b0;
            end else if (scl_rise) begin
                if (state_r == ST_TX_ACK) begin
                    ack_r <= ~sda_s_r;
                end else if (rx_state) begin
                    shift_r <= {shift_r[6:0], sda_s_r};
                    cnt_r <= cnt_r + 4'h1;
                end
            end else if (scl_fall) begin
                case (state_r)
                    ST_IDLE: begin
                        oe_r <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (cnt_r == BYTE_BITS) begin
                            cnt_r <= 4'h0;
                            if (shift_r[7:1] == SLAVE_ADDR) begin
                                oe_r <= 1'b1;
                                rd_r <= shift_r[0];
                                state_r <= ST_ACK_ADDR;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK_ADDR: begin
                        if (rd_r) begin
                            // Receive Byte and Read Byte both use ptr_r
                            oe_r <= ~rd_byte[7];
                            shift_r <= {rd_byte[6:0], 1'b0};
                            cnt_r <= 4'h1;
                            state_r <= ST_TX;
                        end else begin
                            oe_r <= 1'b0;
                            state_r <= ST_CMD;
                        end
                    end
                    ST_CMD: begin
                        if (cnt_r == BYTE_BITS) begin
                            cnt_r <= 4'h0;
                            oe_r <= 1'b1;
                            cmd_r <= shift_r;
                            state_r <= ST_ACK_CMD;
                            if (shift_r == CMD_SINGLE_CONV) begin
                                os_tog_r <= ~os_tog_r;
                            end else begin
                                ptr_r <= shift_r;
                            end
                        end
                    end
                    ST_ACK_CMD: begin
                        oe_r <= 1'b0;
                        state_r <= ST_DATA;
                    end
                    ST_DATA: begin
                        if (cnt_r == BYTE_BITS) begin
                            cnt_r <= 4'h0;
                            oe_r <= 1'b1;
                            state_r <= ST_ACK_DATA;
                            if (wr_cmd(cmd_r)) begin
                                we_r <= 1'b1;
                                waddr_r <= 4'(cmd_r - WR_TO_RD_OFFSET);
                                wdata_r <= shift_r;
                            end
                            if (cmd_r == CMD_WR_CFG) begin
                                halt_cfg_r <= shift_r[CFG_HALT_BIT];
                            end
                        end
                    end
                    ST_ACK_DATA: begin
                        oe_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                    ST_TX: begin
                        if (cnt_r == BYTE_BITS) begin
                            oe_r <= 1'b0;
                            state_r <= ST_TX_ACK;
                        end else begin
                            oe_r <= ~shift_r[7];
                            shift_r <= {shift_r[6:0], 1'b0};
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                    ST_TX_ACK: begin
                        if (ack_r) begin
                            oe_r <= ~rd_byte[7];
                            shift_r <= {rd_byte[6:0], 1'b0};
                            cnt_r <= 4'h1;
                            state_r <= ST_TX;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                    default: begin
                        oe_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_r;

endmodule
`default_nettype wire

//--- sim/tsb_temp_ctrl_sva.sv
/*
 * Checker of the thermometer slave: standby, conversion and SDA drive.
 * Assumes it is bound to tsb_temp_ctrl and sees only that module's ports.
 */
`timescale 1ns/1ns
`default_nettype none
module tsb_temp_ctrl_sva #(
    parameter int CONV_CYCLES_P = 200
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic hw_sleep_n_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic adc_run_o,
    input wire logic standby_o
);
    a_sleep_halts_run: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!hw_sleep_n_i) [*4] |=> !adc_run_o)
        else $error("conversion runs with sleep pin low");
    a_sleep_sets_hw_sleep_n: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!hw_sleep_n_i) [*4] |=> standby_o)
        else $error("no standby with sleep pin low");
    a_hw_sleep_n_exit_pin: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $fell(standby_o) |-> $past(hw_sleep_n_i, 2) ||
        $past(hw_sleep_n_i, 3) || $past(hw_sleep_n_i, 4))
        else $error("standby left while sleep pin low");
    a_run_needs_pin: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(adc_run_o) |-> $past(hw_sleep_n_i, 2) ||
        $past(hw_sleep_n_i, 3) || $past(hw_sleep_n_i, 4))
        else $error("conversion started with sleep pin low");
    a_hw_sleep_n_run_apart: assert property (
        @(posedge clk_i) disable iff (rst_i)
        not ((standby_o && adc_run_o) [*3]))
        else $error("standby and conversion together");
    // Data line may only move while the clock is low
    a_oe_scl_low: assert property (
        @(posedge link_clk_i) disable iff (rst_i)
        $changed(sda_oe_o) |-> !scl_i)
        else $error("data drive changed with clock high");
    a_oe_after_fall: assert property (
        @(posedge link_clk_i) disable iff (rst_i)
        $changed(sda_oe_o) |-> $past(scl_i, 2) || $past(scl_i, 3) ||
        $past(scl_i, 4) || $past(scl_i, 5) || $past(scl_i, 6))
        else $error("data drive changed without a clock fall");
    a_drive_low_only: assert property (
        @(posedge link_clk_i) disable iff (rst_i)
        sda_oe_o |-> !sda_o)
        else $error("data line driven high");
endmodule
bind tsb_temp_ctrl tsb_temp_ctrl_sva #(.CONV_CYCLES_P(CONV_CYCLES_P)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
    .hw_sleep_n_i(hw_sleep_n_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .adc_run_o(adc_run_o), .standby_o(standby_o));
`default_nettype wire

//--- sim/tsb_host_bfm.sv
/*
 * Behavioural SMBus host master, single master on the bus.
 * Assumes the bench resolves the pulled-up data wire; 1 = released.
 */
`timescale 1ns/1ns
`default_nettype none
module tsb_host_bfm #(
    parameter int HALF_NS = 400
) (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Data moves a quarter phase after the clock falls, never with it
    task automatic start_c;
        #(HALF_NS / 4) sda_o = 1'b1;
        #HALF_NS scl_o = 1'b1;
        #HALF_NS sda_o = 1'b0;
        #HALF_NS scl_o = 1'b0;
    endtask
    task automatic stop_c;
        #(HALF_NS / 4) sda_o = 1'b0;
        #HALF_NS scl_o = 1'b1;
        #HALF_NS sda_o = 1'b1;
    endtask
    task automatic bit_c(input logic b, output logic s);
        #(HALF_NS / 4) sda_o = b;
        #(HALF_NS * 3 / 4) scl_o = 1'b1;
        s = sda_i;
        #HALF_NS scl_o = 1'b0;
    endtask
    task automatic put(input logic [7:0] b, output logic nak);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(b[i], s);
        end
        bit_c(1'b1, nak);
    endtask
    task automatic get(output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(1'b1, s);
            b[i] = s;
        end
        bit_c(1'b1, s);
    endtask
    // Mode 0 write, 1 read, 2 send, 3 receive; short ones are safe alone
    task automatic xfer(input logic [1:0] m, input logic [6:0] a,
                        input logic [7:0] c, input logic [7:0] w,
                        output logic [7:0] r, output logic nak);
        logic n0, n1, n2;
        n1 = 1'b0;
        n2 = 1'b0;
        r = 8'h00;
        start_c();
        put({a, m == 2'h3}, n0);
        if (m != 2'h3) begin
            put(c, n1);
        end
        if (m == 2'h0) begin
            put(w, n2);
        end
        if (m == 2'h1) begin
            start_c();
            put({a, 1'b1}, n2);
        end
        if (m[0]) begin
            get(r);
        end
        stop_c();
        nak = n0 | n1 | n2;
    endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
/*
 * Self-checking bench of tsb_temp_ctrl driven by a behavioural host.
 * Assumes tsb_host_bfm and a pulled-up SMBus data wire.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import tsb_pkg::*;
    localparam int CONV = 2000;
    localparam logic [6:0] ADDR = 7'h2A;
    logic clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hw_sleep_n_i = 1'b1;
    logic signed [RAW_W-1:0] adc_l = '0;
    logic signed [RAW_W-1:0] adc_r = '0;
    wire logic scl_w;
    wire logic host_sda;
    wire logic dut_sda;
    wire logic dut_oe;
    wire logic run;
    wire logic hw_sleep_n;
    wire logic sda_w = host_sda & ~(dut_oe & ~dut_sda);
    logic [7:0] por [6] = '{8'h00, 8'h02, 8'h7F, 8'hC9, 8'h7F, 8'hC9};
    logic [7:0] rd, v, el, er;
    logic nak;
    int err_total = 0;
    int comparisons = 0;
    int n;
    int hi = 0;
    int last = 0;
    tsb_temp_ctrl #(.CONV_CYCLES_P(CONV), .SLAVE_ADDR(ADDR)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
        .scl_i(scl_w), .sda_i(sda_w), .hw_sleep_n_i(hw_sleep_n_i),
        .adc_local_i(adc_l), .adc_remote_i(adc_r), .sda_o(dut_sda),
        .sda_oe_o(dut_oe), .adc_run_o(run), .standby_o(hw_sleep_n));
    tsb_host_bfm host_u (.sda_i(sda_w), .scl_o(scl_w), .sda_o(host_sda));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // Odd offset keeps the link clock out of step with the system clock
    initial begin
        #17;
        forever #32 link_clk_i = ~link_clk_i;
    end
    always @(negedge clk_i) begin
        if (run === 1'b1) begin
            hi <= hi + 1;
        end else if (hi != 0) begin
            last <= hi;
            hi <= 0;
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h not %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] exp_t(input logic signed [RAW_W-1:0] q);
        int d;
        d = (int'(q) + 2) >>> 2;
        d = (d > 127) ? 127 : (d < -128) ? -128 : d;
        return d[7:0];
    endfunction
    task automatic bus(input logic [1:0] m, input logic [7:0] c,
                       input logic [7:0] w);
        host_u.xfer(m, ADDR, c, w, rd, nak);
        chk(16'(nak), 16'h0000);
    endtask
    task automatic wait_run(input logic lvl, input int lim);
        n = 0;
        while (run !== lvl) begin
            @(negedge clk_i);
            n++;
            if (n > lim) begin
                err_total++;
                $display("unexpected at %0t: wait ran out", $time);
                close_out();
            end
        end
    endtask
    initial begin
        void'($urandom(83284));
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < 6; i++) begin
            bus(2'h1, 8'(i + 3), 8'h00);
            chk(16'(rd), 16'(por[i]));
        end
        $display("test reset values done");
        for (int c = 10; c <= 14; c++) begin
            v = 8'($urandom);
            bus(2'h0, 8'(c), v);
            bus(2'h3, 8'h00, 8'h00);
            chk(16'(rd), 16'(v));
            bus(2'h1, 8'(c - 6), 8'h00);
            chk(16'(rd), 16'(v));
            bus(2'h3, 8'h00, 8'h00);
            chk(16'(rd), 16'(v));
        end
        bus(2'h2, 8'h0F, 8'h00);
        bus(2'h3, 8'h00, 8'h00);
        chk(16'(rd), 16'(v));
        host_u.xfer(2'h0, ADDR ^ 7'h01, 8'h0E, ~v, rd, nak);
        chk(16'(nak), 16'h0001);
        bus(2'h1, 8'h08, 8'h00);
        chk(16'(rd), 16'(v));
        $display("test transfers done");
        bus(2'h0, 8'h09, 8'h40);
        for (int k = 0; k < 4; k++) begin
            wait_run(1'b0, CONV + 10);
            @(negedge clk_i);
            adc_l = (k == 0) ? 11'sh002 : (k == 1) ? 11'sh1FA : 11'($urandom);
            adc_r = (k == 0) ? 11'sh7FD : (k == 1) ? 11'sh7FE : 11'($urandom);
            bus(2'h2, 8'h0F, 8'h00);
            wait_run(1'b1, 20);
            wait_run(1'b0, CONV + 10);
            @(negedge clk_i);
            chk(16'(last), 16'(CONV));
            el = exp_t(adc_l);
            er = exp_t(adc_r);
            bus(2'h1, 8'h00, 8'h00);
            chk(16'(rd), 16'(el));
            bus(2'h1, 8'h01, 8'h00);
            chk(16'(rd), 16'(er));
        end
        repeat (3) @(negedge clk_i);
        chk(16'(hw_sleep_n), 16'h0001);
        $display("test single conversions done");
        adc_l = adc_l ^ 11'sh100;
        adc_r = adc_r ^ 11'sh100;
        bus(2'h2, 8'h0F, 8'h00);
        wait_run(1'b1, 20);
        bus(2'h1, 8'h02, 8'h00);
        chk(16'(rd), 16'h0080);
        repeat (50) @(negedge clk_i);
        hw_sleep_n_i = 1'b0;
        wait_run(1'b0, 10);
        repeat (4) @(negedge clk_i);
        chk(16'(hw_sleep_n), 16'h0001);
        bus(2'h1, 8'h02, 8'h00);
        chk(16'(rd), 16'h0000);
        bus(2'h1, 8'h00, 8'h00);
        chk(16'(rd), 16'(el));
        bus(2'h0, 8'h0B, 8'h5A);
        bus(2'h1, 8'h05, 8'h00);
        chk(16'(rd), 16'h005A);
        // Neither a single conversion nor free running may beat the pin
        bus(2'h2, 8'h0F, 8'h00);
        bus(2'h0, 8'h09, 8'h00);
        n = 0;
        repeat (300) begin
            @(negedge clk_i);
            n += int'(run !== 1'b0);
        end
        chk(16'(n), 16'h0000);
        $display("test pin standby done");
        hw_sleep_n_i = 1'b1;
        wait_run(1'b1, 10);
        chk(16'(n), 16'h0003);
        bus(2'h0, 8'h09, 8'h40);
        wait_run(1'b0, 20);
        bus(2'h1, 8'h01, 8'h00);
        chk(16'(rd), 16'(er));
        $display("test halt abort done");
        close_out();
    end
endmodule
`default_nettype wire
